// File: hw/i2hs_host.sv
// Host end: I2C master issuing register writes, pointer-then-read frames and HS entry
`timescale 1ns/10ps
module i2hs_host
   import i2hs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   i2hs_bus_if.host        bus,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic       cmd_read,
   input  wire logic       cmd_hs,
   input  wire logic [6:0] cmd_dev_addr,
   input  wire logic [7:0] cmd_reg,
   input  wire logic [7:0] cmd_len,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_valid,
   output logic            wr_ready,
   output logic [7:0]      rd_data,
   output logic            rd_valid,
   output logic            done,
   output logic            nack_err,
   output logic            hs_active
);
   i2hs_hst_e   st_reg;
   i2hs_hbyte_e kind_reg;
   logic [1:0]  sub_reg;
   logic [3:0]  cnt_reg;
   logic [7:0]  sh_reg;
   logic [7:0]  len_reg;
   logic [7:0]  regad_reg;
   logic [6:0]  dev_reg;
   logic        rd_reg;
   logic        hs_reg;
   logic        acked_reg;
   logic        scl_oe_reg;
   logic        sda_oe_reg;
   logic [7:0]  rdat_reg;
   logic        rdv_reg;
   logic        done_reg;
   logic        err_reg;
   logic [DIV_W-1:0] div_reg;
   logic        tick;
   logic        decide;
   logic        need_wd;

   assign bus.host_scl_o  = 1'b0;
   assign bus.host_sda_o  = 1'b0;
   assign bus.host_scl_oe = scl_oe_reg;
   assign bus.host_sda_oe = sda_oe_reg;

   // Half-bit enable; faster rate once the master code has gone out
   always_ff @(posedge clk) begin
      if (srst || st_reg == H_IDLE) begin
         div_reg <= '0;
      end else if (div_reg == '0) begin
         div_reg <= hs_reg ? DIV_W'(HALF_HS - 1) : DIV_W'(HALF_FS - 1);
      end else begin
         div_reg <= div_reg - 1'b1;
      end
   end
   assign tick = (st_reg != H_IDLE) && (div_reg == '0);

   assign decide    = tick && st_reg == H_TX && sub_reg == 2'h3;
   assign need_wd   = acked_reg && len_reg != 8'h00 &&
                      (kind_reg == B_WD || (kind_reg == B_REG && !rd_reg));
   assign wr_ready  = decide && need_wd;
   assign cmd_ready = (st_reg == H_IDLE);

   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg     <= H_IDLE;
         kind_reg   <= B_AW;
         sub_reg    <= 2'h0;
         cnt_reg    <= 4'h0;
         sh_reg     <= 8'h00;
         len_reg    <= 8'h00;
         regad_reg  <= 8'h00;
         dev_reg    <= 7'h00;
         rd_reg     <= 1'b0;
         hs_reg     <= 1'b0;
         acked_reg  <= 1'b0;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         rdat_reg   <= 8'h00;
         rdv_reg    <= 1'b0;
         done_reg   <= 1'b0;
         err_reg    <= 1'b0;
      end else begin
         rdv_reg  <= 1'b0;
         done_reg <= 1'b0;
         if (st_reg == H_IDLE) begin
            if (cmd_valid) begin
               dev_reg   <= cmd_dev_addr;
               regad_reg <= cmd_reg;
               len_reg   <= cmd_len;
               rd_reg    <= cmd_read;
               err_reg   <= 1'b0;
               sub_reg   <= 2'h0;
               cnt_reg   <= 4'h0;
               st_reg    <= H_ST;
               kind_reg  <= cmd_hs ? B_MC : B_AW;
               sh_reg    <= cmd_hs ? MCODE_BYTE : {cmd_dev_addr, 1'b0};
            end
         end else if (tick) begin
            unique case (st_reg)
               H_ST: begin
                  sub_reg <= sub_reg + 2'h1;
                  unique case (sub_reg)
                     2'h0: sda_oe_reg <= 1'b0;
                     2'h1: scl_oe_reg <= 1'b0;
                     2'h2: sda_oe_reg <= 1'b1;
                     2'h3: begin
                        scl_oe_reg <= 1'b1;
                        st_reg     <= H_TX;
                     end
                  endcase
               end
               H_TX: begin
                  unique case (sub_reg)
                     2'h0: begin
                        sda_oe_reg <= (cnt_reg == BIT_LAST) ? 1'b0 : !sh_reg[7];
                        sub_reg    <= 2'h1;
                     end
                     2'h1: begin
                        scl_oe_reg <= 1'b0;
                        sub_reg    <= 2'h2;
                     end
                     2'h2: begin
                        scl_oe_reg <= 1'b1;
                        if (cnt_reg == BIT_LAST) begin
                           acked_reg <= !bus.sda;
                           sub_reg   <= 2'h3;
                        end else begin
                           sh_reg  <= {sh_reg[6:0], 1'b0};
                           cnt_reg <= cnt_reg + 4'h1;
                           sub_reg <= 2'h0;
                        end
                     end
                     2'h3: begin
                        cnt_reg <= 4'h0;
                        sub_reg <= 2'h0;
                        if (kind_reg == B_MC) begin
                           // Master code is answered by nobody; go fast, Sr
                           hs_reg   <= 1'b1;
                           kind_reg <= B_AW;
                           sh_reg   <= {dev_reg, 1'b0};
                           st_reg   <= H_ST;
                        end else if (!acked_reg) begin
                           err_reg <= 1'b1;
                           st_reg  <= H_SP;
                        end else if (kind_reg == B_AW) begin
                           kind_reg <= B_REG;
                           sh_reg   <= regad_reg;
                        end else if (kind_reg == B_AR) begin
                           kind_reg <= B_RD;
                           st_reg   <= H_RX;
                        end else if (len_reg == 8'h00) begin
                           st_reg <= H_SP;
                        end else if (kind_reg == B_REG && rd_reg) begin
                           // Address-only write done, read via Sr
                           kind_reg <= B_AR;
                           sh_reg   <= {dev_reg, 1'b1};
                           st_reg   <= H_ST;
                        end else if (need_wd && wr_valid) begin
                           kind_reg <= B_WD;
                           sh_reg   <= wr_data;
                           len_reg  <= len_reg - 8'h01;
                        end else begin
                           sub_reg <= 2'h3;
                        end
                     end
                  endcase
               end
               H_RX: begin
                  unique case (sub_reg)
                     2'h0: begin
                        sda_oe_reg <= (cnt_reg == BIT_LAST) && (len_reg != 8'h01);
                        sub_reg    <= 2'h1;
                     end
                     2'h1: begin
                        scl_oe_reg <= 1'b0;
                        sub_reg    <= 2'h2;
                     end
                     default: begin
                        scl_oe_reg <= 1'b1;
                        sub_reg    <= 2'h0;
                        if (cnt_reg == BIT_LAST) begin
                           rdat_reg <= sh_reg;
                           rdv_reg  <= 1'b1;
                           len_reg  <= len_reg - 8'h01;
                           cnt_reg  <= 4'h0;
                           st_reg   <= (len_reg == 8'h01) ? H_SP : H_RX;
                        end else begin
                           sh_reg  <= {sh_reg[6:0], bus.sda};
                           cnt_reg <= cnt_reg + 4'h1;
                        end
                     end
                  endcase
               end
               default: begin
                  sub_reg <= sub_reg + 2'h1;
                  unique case (sub_reg)
                     2'h0: sda_oe_reg <= 1'b1;
                     2'h1: scl_oe_reg <= 1'b0;
                     default: begin
                        sda_oe_reg <= 1'b0;
                        hs_reg     <= 1'b0;
                        done_reg   <= 1'b1;
                        sub_reg    <= 2'h0;
                        st_reg     <= H_IDLE;
                     end
                  endcase
               end
            endcase
         end
      end
   end

   assign rd_data   = rdat_reg;
   assign rd_valid  = rdv_reg;
   assign done      = done_reg;
   assign nack_err  = err_reg;
   assign hs_active = hs_reg;
endmodule

// File: hw/i2hs_pkg.sv
// Shared constants and types for the I2C slave register-access link with high-speed mode
// Notes on behaviour
// - Host sets pointer with address-only write first
// - Read frame returns previously selected register contents
// - Read bytes all from same register, no increment
// - HS entry: START, master code 00001XXX, not-acknowledge
// - In HS, Sr plus slave address gets acknowledged
// - HS held across Sr, dropped only on STOP
// - After reset the link runs in Fast mode
// - Master code switches input filters and output slope
// - Force bit holds high-speed mode while it is set
// - Host forces HS only on a private bus
// - Without master code the link stays Fast/Standard
// - HS mode supports up to 3.4 Mbit/s
// - Device is slave only, never drives SCL
// - Write frame data bytes all hit one register
// - Slave address pins latched once after reset
package i2hs_pkg;
   localparam int CLK_KHZ = 200000;
   localparam int FS_KHZ  = 400;
   localparam int HS_KHZ  = 3400;
   // Shortest half period of SCL in clk cycles, rounded up
   localparam int HALF_FS = (CLK_KHZ + 2 * FS_KHZ - 1) / (2 * FS_KHZ);
   localparam int HALF_HS = (CLK_KHZ + 2 * HS_KHZ - 1) / (2 * HS_KHZ);
   localparam int DIV_W   = 9;

   localparam logic [4:0] MCODE_HI   = 5'h01;
   localparam logic [7:0] MCODE_BYTE = 8'h08;
   localparam logic [3:0] ADDR_FIX_HI = 4'h5;
   localparam logic [3:0] BIT_LAST   = 4'h8;

   typedef enum logic [2:0] {
      D_IDLE  = 3'b000,
      D_RX    = 3'b001,
      D_ACK   = 3'b010,
      D_TX    = 3'b011,
      D_TXACK = 3'b100,
      D_WAIT  = 3'b101
   } i2hs_dst_e;

   typedef enum logic [1:0] {
      K_ADDR = 2'b00,
      K_REG  = 2'b01,
      K_DATA = 2'b10
   } i2hs_kind_e;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_ST   = 3'b001,
      H_TX   = 3'b010,
      H_RX   = 3'b011,
      H_SP   = 3'b100
   } i2hs_hst_e;

   typedef enum logic [2:0] {
      B_MC  = 3'b000,
      B_AW  = 3'b001,
      B_REG = 3'b010,
      B_WD  = 3'b011,
      B_AR  = 3'b100,
      B_RD  = 3'b101
   } i2hs_hbyte_e;
endpackage

// File: hw/i2hs_bus_if.sv
// Open-drain SCL/SDA wiring between host and device ends
`timescale 1ns/10ps
interface i2hs_bus_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // Wired-AND with pull-up: any enabled low driver pulls the line low
   assign scl = !(host_scl_oe && !host_scl_o);
   assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

   modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                 output host_sda_o, output host_sda_oe);
endinterface

// File: hw/i2hs_cond_det.sv
// Detector for START, STOP and SCL edges on sampled bus lines
`timescale 1ns/10ps
module i2hs_cond_det
   import i2hs_pkg::*;
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic scl,
   input  wire logic sda,
   output logic      start,
   output logic      stop,
   output logic      scl_rise,
   output logic      scl_fall
);
   logic scl_q_reg;
   logic sda_q_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= scl;
         sda_q_reg <= sda;
      end
   end

   assign start    = scl && scl_q_reg && sda_q_reg && !sda;
   assign stop     = scl && scl_q_reg && !sda_q_reg && sda;
   assign scl_rise = scl && !scl_q_reg;
   assign scl_fall = !scl && scl_q_reg;
endmodule

// File: hw/i2hs_dev.sv
// Device end: I2C slave with register pointer, same-register streaming and HS mode switch
`timescale 1ns/10ps
module i2hs_dev
   import i2hs_pkg::*;
#(
   parameter int ADR_PINS = 6
) (
   input  wire logic                clk,
   input  wire logic                srst,
   i2hs_bus_if.dev                  bus,
   input  wire logic [ADR_PINS-1:0] addr_pins,
   input  wire logic                address_mode_select_pin,
   input  wire logic                force_high_speed_bit,
   input  wire logic [7:0]          reg_rdata,
   output logic [7:0]               reg_addr,
   output logic [7:0]               reg_wdata,
   output logic                     reg_wr,
   output logic                     reg_rd,
   output logic [6:0]               own_addr,
   output logic                     hs_input_filter,
   output logic                     hs_output_slope,
   output logic                     busy
);
   logic        start;
   logic        stop;
   logic        rise;
   logic        fall;
   logic        sda;

   i2hs_dst_e   st_reg;
   i2hs_kind_e  kind_reg;
   logic [7:0]  sh_reg;
   logic [3:0]  cnt_reg;
   logic        rd_reg;
   logic        oe_reg;
   logic [7:0]  ptr_reg;
   logic [7:0]  wdata_reg;
   logic        wr_reg;
   logic        rdp_reg;
   logic        mc_reg;
   logic        hs_reg;
   logic        hs_eff;
   logic [6:0]  own_reg;
   logic        latched_reg;
   logic        filt_reg;
   logic        slope_reg;
   logic [6:0]  own_next;

   assign sda = bus.sda;

   i2hs_cond_det u_det (
      .clk      (clk),
      .srst     (srst),
      .scl      (bus.scl),
      .sda      (sda),
      .start    (start),
      .stop     (stop),
      .scl_rise (rise),
      .scl_fall (fall)
   );

   // SCL is only ever observed, SDA only pulled low or released
   assign bus.dev_sda_o  = 1'b0;
   assign bus.dev_sda_oe = oe_reg;

   // Address straps: fixed upper nibble or six free pins
   always_comb begin
      if (address_mode_select_pin) begin
         own_next = {1'b0, addr_pins[5:0]};
      end else begin
         own_next = {ADDR_FIX_HI, addr_pins[2:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         own_reg     <= 7'h00;
         latched_reg <= 1'b0;
      end else if (!latched_reg) begin
         own_reg     <= own_next;
         latched_reg <= 1'b1;
      end
   end

   // Speed mode: Fast after reset, HS after master code, back on STOP
   always_ff @(posedge clk) begin
      if (srst) begin
         hs_reg <= 1'b0;
      end else if (stop) begin
         hs_reg <= 1'b0;
      end else if (mc_reg) begin
         hs_reg <= 1'b1;
      end
   end

   assign hs_eff = hs_reg || force_high_speed_bit;

   // Filter and slope select follow the speed mode; HS covers 3.4 Mbit/s
   always_ff @(posedge clk) begin
      if (srst) begin
         filt_reg  <= 1'b0;
         slope_reg <= 1'b0;
      end else begin
         filt_reg  <= hs_eff;
         slope_reg <= hs_eff;
      end
   end

   // Byte engine
   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg    <= D_IDLE;
         kind_reg  <= K_ADDR;
         sh_reg    <= 8'h00;
         cnt_reg   <= 4'h0;
         rd_reg    <= 1'b0;
         oe_reg    <= 1'b0;
         ptr_reg   <= 8'h00;
         wdata_reg <= 8'h00;
         wr_reg    <= 1'b0;
         rdp_reg   <= 1'b0;
         mc_reg    <= 1'b0;
      end else begin
         wr_reg  <= 1'b0;
         rdp_reg <= 1'b0;
         mc_reg  <= 1'b0;
         if (start) begin
            // Repeated START keeps the speed mode, restarts addressing
            st_reg   <= D_RX;
            kind_reg <= K_ADDR;
            cnt_reg  <= 4'h0;
            oe_reg   <= 1'b0;
         end else if (stop) begin
            st_reg <= D_IDLE;
            oe_reg <= 1'b0;
         end else begin
            unique case (st_reg)
               D_IDLE, D_WAIT: begin
               end
               D_RX: begin
                  if (rise && cnt_reg < BIT_LAST) begin
                     sh_reg  <= {sh_reg[6:0], sda};
                     cnt_reg <= cnt_reg + 4'h1;
                  end else if (fall && cnt_reg == BIT_LAST) begin
                     cnt_reg <= 4'h0;
                     unique case (kind_reg)
                        K_ADDR: begin
                           if (sh_reg[7:3] == MCODE_HI) begin
                              // Master code: leave SDA released
                              mc_reg <= 1'b1;
                              st_reg <= D_WAIT;
                           end else if (latched_reg && sh_reg[7:1] == own_reg) begin
                              oe_reg   <= 1'b1;
                              rd_reg   <= sh_reg[0];
                              kind_reg <= K_REG;
                              st_reg   <= D_ACK;
                           end else begin
                              st_reg <= D_WAIT;
                           end
                        end
                        K_REG: begin
                           ptr_reg  <= sh_reg;
                           kind_reg <= K_DATA;
                           oe_reg   <= 1'b1;
                           st_reg   <= D_ACK;
                        end
                        default: begin
                           // Every data byte lands on the same pointer
                           wdata_reg <= sh_reg;
                           wr_reg    <= 1'b1;
                           oe_reg    <= 1'b1;
                           st_reg    <= D_ACK;
                        end
                     endcase
                  end
               end
               D_ACK: begin
                  if (fall) begin
                     if (rd_reg) begin
                        sh_reg  <= reg_rdata;
                        rdp_reg <= 1'b1;
                        oe_reg  <= !reg_rdata[7];
                        cnt_reg <= 4'h1;
                        st_reg  <= D_TX;
                     end else begin
                        oe_reg <= 1'b0;
                        st_reg <= D_RX;
                     end
                  end
               end
               D_TX: begin
                  if (fall) begin
                     if (cnt_reg == BIT_LAST) begin
                        oe_reg <= 1'b0;
                        st_reg <= D_TXACK;
                     end else begin
                        oe_reg  <= !sh_reg[6];
                        sh_reg  <= {sh_reg[6:0], 1'b0};
                        cnt_reg <= cnt_reg + 4'h1;
                     end
                  end
               end
               D_TXACK: begin
                  if (rise && sda) begin
                     st_reg <= D_WAIT;
                  end else if (fall) begin
                     // Next byte again from the unchanged pointer
                     sh_reg  <= reg_rdata;
                     rdp_reg <= 1'b1;
                     oe_reg  <= !reg_rdata[7];
                     cnt_reg <= 4'h1;
                     st_reg  <= D_TX;
                  end
               end
               default: begin
                  st_reg <= D_IDLE;
               end
            endcase
         end
      end
   end

   assign reg_addr        = ptr_reg;
   assign reg_wdata       = wdata_reg;
   assign reg_wr          = wr_reg;
   assign reg_rd          = rdp_reg;
   assign own_addr        = own_reg;
   assign hs_input_filter = filt_reg;
   assign hs_output_slope = slope_reg;
   assign busy            = (st_reg != D_IDLE);
endmodule

// File: tb/i2hs_chk.sv
// Checker of the wired SCL/SDA link between the host and device ends
`timescale 1ns/10ps
module i2hs_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic scl,
   input wire logic sda,
   input wire logic host_scl_oe,
   input wire logic dev_sda_oe
);
   logic       scl_reg, sda_reg, first_reg, mc_reg, hs_reg;
   logic [3:0] nbit_reg;
   logic [7:0] sh_reg;
   logic [8:0] low_reg;
   wire        st   = scl_reg && scl && sda_reg && !sda;
   wire        sp   = scl_reg && scl && !sda_reg && sda;
   wire        rise = scl && !scl_reg;
   wire        mc9  = rise && first_reg && nbit_reg == 4'h8 && sh_reg[7:3] == 5'h01;
   // Line history and length of the current clock-low phase
   always_ff @(posedge clk) begin
      scl_reg <= scl;
      sda_reg <= sda;
      low_reg <= scl ? 9'h000 : ((low_reg == 9'h1FF) ? low_reg : low_reg + 9'h001);
   end
   // Bit position inside a byte, first byte after each start
   always_ff @(posedge clk) begin
      if (srst || st) begin
         nbit_reg  <= 4'h0;
         first_reg <= 1'b1;
      end else if (rise) begin
         nbit_reg  <= (nbit_reg == 4'h8) ? 4'h0 : nbit_reg + 4'h1;
         sh_reg    <= {sh_reg[6:0], sda};
         first_reg <= first_reg && nbit_reg != 4'h8;
      end
   end
   // Fast rate until master code and restart, back on stop
   always_ff @(posedge clk) begin
      if (srst || sp) begin
         mc_reg <= 1'b0;
         hs_reg <= 1'b0;
      end else begin
         mc_reg <= mc_reg || mc9;
         hs_reg <= hs_reg || (st && mc_reg);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence ack_hold_s;
      dev_sda_oe [*8];
   endsequence
   dev_stable_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device data moved while clock high");
   dev_rise_a: assert property ($rose(dev_sda_oe) |-> !scl)
      else $error("device drive began with clock high");
   ack_hold_a: assert property ($rose(dev_sda_oe) |=> ack_hold_s)
      else $error("device drive too short");
   start_free_a: assert property (st |-> !dev_sda_oe)
      else $error("device made a start");
   host_low_a: assert property ($rose(host_scl_oe) |=> host_scl_oe [*8])
      else $error("clock low phase too short");
   mc_nack_a: assert property (mc9 |-> !dev_sda_oe)
      else $error("master code acknowledged");
   fs_low_a: assert property (rise && !mc_reg && !hs_reg |-> low_reg >= 9'h190)
      else $error("fast rate clock low too short");
   // Low phase is two half periods, three where the host decides on the next byte
   hs_low_a: assert property (rise && hs_reg |-> low_reg inside {[9'h03C:9'h05A]})
      else $error("high speed rate not kept");
endmodule

// File: tb/i2c_slave_register_access_hs_tb.sv
// Bench joining the host and device ends and checking both user sides
`timescale 1ns/10ps
module i2c_slave_register_access_hs_tb;
   logic       clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0, cmd_read = 1'b0, cmd_hs = 1'b0;
   logic       address_mode_select_pin = 1'b0, force_high_speed_bit = 1'b0;
   logic [5:0] addr_pins = 6'h00;
   logic [6:0] cmd_dev_addr = 7'h00, own_addr, own_exp;
   logic [7:0] cmd_reg = 8'h00, cmd_len = 8'h00, wr_data, rd_data, reg_rdata, reg_addr;
   logic [7:0] reg_wdata, rexp, creg, wdat [16], rf [256] = '{default: 8'h00};
   logic       cmd_ready, wr_ready, rd_valid, done, nack_err, hs_active, reg_wr, reg_rd;
   logic       hs_input_filter, hs_output_slope, busy;
   int         wi, wc, rc, num_errors, num_checks, mdl [256];
   always #2.5 clk = ~clk;
   assign wr_data   = wdat[wi[3:0]];
   assign reg_rdata = rf[reg_addr];
   i2hs_bus_if i2hs_bus_if_i ();
   i2hs_host i2hs_host_i (.clk, .srst, .bus(i2hs_bus_if_i.host), .cmd_valid, .cmd_ready,
      .cmd_read, .cmd_hs, .cmd_dev_addr, .cmd_reg, .cmd_len, .wr_data, .wr_valid(1'b1),
      .wr_ready, .rd_data, .rd_valid, .done, .nack_err, .hs_active);
   i2hs_dev i2hs_dev_i (.clk, .srst, .bus(i2hs_bus_if_i.dev), .addr_pins,
      .address_mode_select_pin, .force_high_speed_bit, .reg_rdata, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .own_addr, .hs_input_filter, .hs_output_slope, .busy);
   i2hs_chk i2hs_chk_i (.clk, .srst, .scl(i2hs_bus_if_i.scl), .sda(i2hs_bus_if_i.sda),
      .host_scl_oe(i2hs_bus_if_i.host_scl_oe), .dev_sda_oe(i2hs_bus_if_i.dev_sda_oe));
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      num_checks++;
      if (seen !== want) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic run(input logic rd, input logic hs, input logic [6:0] dev,
                      input logic [7:0] rg, input logic [7:0] ln, input logic ack);
      int   n;
      logic [1:0] seen;
      @(posedge clk);
      creg = rg;
      wc   = 0;
      rc   = 0;
      wi   = 0;
      seen = 2'h0;
      rexp = 8'(mdl[rg]);
      for (n = 0; n < 16; n++) wdat[n] = 8'($urandom);
      cmd_read     <= rd;
      cmd_hs       <= hs;
      cmd_dev_addr <= dev;
      cmd_reg      <= rg;
      cmd_len      <= ln;
      cmd_valid    <= 1'b1;
      for (n = 0; n < 40000 && done !== 1'b1; n++) begin
         @(posedge clk);
         if (cmd_ready === 1'b1) cmd_valid <= 1'b0;
         seen = seen | {hs_active, hs_output_slope};
      end
      if (n == 40000) begin
         num_errors++;
         close_out();
      end
      for (n = 0; n < 20 && hs_input_filter !== 1'b0; n++) @(posedge clk);
      if (n == 20) begin
         num_errors++;
         close_out();
      end
      @(posedge clk);
      chk({7'h00, nack_err}, {7'h00, !ack});
      chk(8'(wc), (ack && !rd) ? ln : 8'h00);
      chk(8'(rc), (ack && rd) ? ln : 8'h00);
      chk({4'h0, busy, seen, hs_input_filter}, {4'h0, 1'b0, hs, hs, 1'b0});
      if (ack) begin
         chk(reg_addr, rg);
         mdl[rg] = rd ? mdl[rg] + ln : wdat[ln - 8'h01];
      end
   endtask
   // Register file behind the device; each read increments the register value by one
   always @(posedge clk) begin
      if (wr_ready === 1'b1) wi <= wi + 1;
      if (reg_wr === 1'b1) begin
         chk(reg_addr, creg);
         chk(reg_wdata, wdat[wc]);
         wc++;
         rf[reg_addr] <= reg_wdata;
      end
      if (reg_rd === 1'b1) rf[reg_addr] <= rf[reg_addr] + 8'h01;
      if (rd_valid === 1'b1) begin
         chk(rd_data, 8'(rexp + rc));
         rc++;
      end
   end
   initial begin
      int k;
      k = $urandom(91);
      for (k = 0; k < 2; k++) begin
         address_mode_select_pin <= k[0];
         // Top pin set keeps the address clear of reserved and master codes
         addr_pins <= 6'($urandom) | 6'h20;
         srst <= 1'b1;
         repeat (6) @(posedge clk);
         srst <= 1'b0;
         @(posedge clk);
         own_exp = k[0] ? {1'b0, addr_pins} : {4'h5, addr_pins[2:0]};
         addr_pins <= ~addr_pins;
         repeat (2) @(posedge clk);
         chk({1'b0, own_addr}, {1'b0, own_exp});
      end
      chk({6'h00, hs_input_filter, hs_output_slope}, 8'h00);
      force_high_speed_bit <= 1'b1;
      repeat (2) @(posedge clk);
      chk({6'h00, hs_input_filter, hs_output_slope}, 8'h03);
      force_high_speed_bit <= 1'b0;
      repeat (2) @(posedge clk);
      run(1'b0, 1'b0, own_exp, 8'h21, 8'h01, 1'b1);
      run(1'b0, 1'b0, own_exp ^ 7'h01, 8'h22, 8'h01, 1'b0);
      run(1'b0, 1'b1, own_exp, 8'h09, 8'h03, 1'b1);
      run(1'b1, 1'b1, own_exp, 8'h09, 8'h03, 1'b1);
      run(1'b1, 1'b1, own_exp, 8'h21, 8'h00, 1'b1);
      run(1'b1, 1'b1, own_exp, 8'h21, 8'h01, 1'b1);
      close_out();
   end
endmodule
